//--- hdl/bpsh_ctrl.sv
// Overview of operation
// - Chip-selected write request starts memory access without waiting on more handshakes.
// - Request crosses to local clock through flip-flops, bounded worst latency.
// - Access request asserts after request seen on two successive edges.
// - Reads launch memory access only once master asserts DS.
// - Intervention during a read turns the access into a memory write.
// - Incoming status is latched on filtered AI, not raw handshake.
// - Intervened or broadcast beats reject short DK and DI glitches.
// - AS, DS and the command pins pass only the synchroniser; only DK, DI and AI glitch-filtered.
// - Outgoing status leaves through latched transceivers on the output strobe.
// - Output strobe launches data and status on its rising edge.
// - AI, DK and DI edges follow data and status launch by a setup delay; AK falls with the strobe.
// - AK is released only after a delay following AS release.
// - Partial transactions are not supported; whole double-words only.
// - Names ending in _n or N are active low, others active high.
module bpsh_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus handshake pins, active low
    input wire logic asN,
    input wire logic dsN,
    input wire logic dkInN,
    input wire logic diInN,
    input wire logic aiInN,
    output logic akN,
    output logic aiN,
    output logic dkN,
    output logic diN,
    // Bus command and status pins, active low
    input wire logic csN,
    input wire logic wrN,
    input wire logic ivN,
    input wire logic bcastN,
    input wire logic [bpsh_pkg::DATA_W-1:0] busData,
    input wire logic [bpsh_pkg::STAT_W-1:0] busStatus,
    // Transceiver and latch controls
    output logic statusDataOutClock,
    output logic latchAddrEn,
    output logic latchStatusEn,
    output logic writeDirN,
    output logic [bpsh_pkg::STAT_W-1:0] rxStatus,
    // Memory module side
    output logic areqN,
    output logic dtStb,
    output logic memWrite,
    input wire logic dack,
    input wire logic acipN,
    // Received write data
    output logic memValid,
    input wire logic memReady,
    output logic [bpsh_pkg::DATA_W-1:0] memData
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [bpsh_pkg::PIN_W-1:0] pinRaw;
    logic [bpsh_pkg::PIN_W-1:0] pinS;

    assign pinRaw = {dack, acipN, bcastN, ivN, wrN, csN, aiInN, diInN, dkInN, dsN, asN};

    // AS, DS and the command pins pass only this synchroniser, no extra filter; DK, DI and AI also pass the glitch filter
    bpsh_sync #(.W(bpsh_pkg::PIN_W), .RST(bpsh_pkg::PIN_RST)) uSync (
        .clk(clk),
        .rst_n(rst_n),
        .din(pinRaw),
        .dout(pinS)
    );

    logic asA;
    logic dsA;
    logic csA;
    logic wrA;
    logic ivA;
    logic bcA;
    logic acipA;
    logic dackS;
    logic [2:0] rawHs;

    // Active-low pins turned to active-high names here only
    assign asA = !pinS[bpsh_pkg::P_AS];
    assign dsA = !pinS[bpsh_pkg::P_DS];
    assign csA = !pinS[bpsh_pkg::P_CS];
    assign wrA = !pinS[bpsh_pkg::P_WR];
    assign ivA = !pinS[bpsh_pkg::P_IV];
    assign bcA = !pinS[bpsh_pkg::P_BC];
    assign acipA = !pinS[bpsh_pkg::P_ACIP];
    assign dackS = pinS[bpsh_pkg::P_DACK];
    assign rawHs = {!pinS[bpsh_pkg::P_AI], !pinS[bpsh_pkg::P_DI], !pinS[bpsh_pkg::P_DK]};

    // ****************************************
    // Glitch filters on received DK, DI, AI
    // ****************************************
    logic [2:0] filt_ff;
    logic [1:0] fcnt_ff [3];
    logic receivedDataAck;
    logic receivedDataAckInverse;
    logic aiFilt;

    assign receivedDataAck = filt_ff[0];
    assign receivedDataAckInverse = filt_ff[1];
    assign aiFilt = filt_ff[2];

    // A new level must persist past the glitch width before it counts
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            filt_ff <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                fcnt_ff[i] <= 2'h0;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (rawHs[i] == filt_ff[i]) begin
                    fcnt_ff[i] <= 2'h0;
                end else if (fcnt_ff[i] == 2'(bpsh_pkg::GLITCH_CYC)) begin
                    filt_ff[i] <= rawHs[i];
                    fcnt_ff[i] <= 2'h0;
                end else begin
                    fcnt_ff[i] <= fcnt_ff[i] + 2'h1;
                end
            end
        end
    end

    // ****************************************
    // Access request synchronisation
    // ****************************************
    logic sel;
    logic launchOk;
    logic areqA_ff;

    assign sel = asA && csA;
    // Reads hold off until DS says whether intervention may occur
    assign launchOk = wrA || dsA;

    // Two local edges must see the request before the memory starts
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            areqA_ff <= 1'b0;
            areqN <= 1'b1;
        end else begin
            areqA_ff <= sel;
            areqN <= !(areqA_ff && sel && launchOk);
        end
    end

    // ****************************************
    // Transaction sequencer
    // ****************************************
    bpsh_pkg::bpsh_state_t state_ff;
    logic [bpsh_pkg::CNT_W-1:0] dly_ff;
    logic ackLvl_ff;
    logic dackSeen_ff;
    logic ivRd_ff;
    logic filtOk;
    logic [2:0] sinceClk_ff;
    bpsh_stream_if #(.W(bpsh_pkg::DATA_W)) wrIf ();
    bpsh_stream_if #(.W(bpsh_pkg::DATA_W)) rdIf ();

    // Intervening or broadcast beats wait for the other boards' answer
    assign filtOk = !(ivRd_ff || bcA) ||
        (ackLvl_ff ? receivedDataAckInverse : receivedDataAck);
    assign wrIf.valid = (state_ff == bpsh_pkg::ST_PUSH);
    assign wrIf.data = busData;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= bpsh_pkg::ST_IDLE;
            dly_ff <= '0;
            ackLvl_ff <= 1'b0;
            dackSeen_ff <= 1'b0;
            ivRd_ff <= 1'b0;
            dtStb <= 1'b0;
            statusDataOutClock <= 1'b0;
            akN <= 1'b1;
            aiN <= 1'b1;
            dkN <= 1'b1;
            diN <= 1'b1;
        end else begin
            statusDataOutClock <= 1'b0;
            case (state_ff)
                bpsh_pkg::ST_IDLE: begin
                    ackLvl_ff <= 1'b0;
                    ivRd_ff <= 1'b0;
                    if (sel) begin
                        state_ff <= bpsh_pkg::ST_ADDR;
                    end
                end
                bpsh_pkg::ST_ADDR: begin
                    // Status out first, then AI after the setup tap
                    akN <= 1'b0;
                    statusDataOutClock <= 1'b1;
                    dly_ff <= bpsh_pkg::CNT_W'(bpsh_pkg::SETUP_CYC);
                    state_ff <= bpsh_pkg::ST_ASETUP;
                end
                bpsh_pkg::ST_ASETUP: begin
                    if (dly_ff != '0) begin
                        dly_ff <= dly_ff - 1'b1;
                    end else begin
                        aiN <= 1'b0;
                        state_ff <= bpsh_pkg::ST_BEAT;
                    end
                end
                bpsh_pkg::ST_BEAT: begin
                    if (!asA) begin
                        statusDataOutClock <= 1'b1;
                        dly_ff <= bpsh_pkg::CNT_W'(bpsh_pkg::DISC_CYC);
                        state_ff <= bpsh_pkg::ST_DISC;
                    end else if (dsA != ackLvl_ff && !areqN) begin
                        // Intervention on a read makes this a memory write
                        if (!wrA && ivA) begin
                            ivRd_ff <= 1'b1;
                        end
                        state_ff <= bpsh_pkg::ST_ACC;
                    end
                end
                bpsh_pkg::ST_ACC: begin
                    dtStb <= !dtStb;
                    state_ff <= bpsh_pkg::ST_WAITD;
                end
                bpsh_pkg::ST_WAITD: begin
                    if (dackS != dackSeen_ff) begin
                        dackSeen_ff <= dackS;
                        state_ff <= (wrA || ivRd_ff) ? bpsh_pkg::ST_PUSH : bpsh_pkg::ST_CLK;
                    end
                end
                bpsh_pkg::ST_PUSH: begin
                    // A full buffer stalls the answer, so no word is lost
                    if (wrIf.ready) begin
                        state_ff <= bpsh_pkg::ST_CLK;
                    end
                end
                bpsh_pkg::ST_CLK: begin
                    // Rising strobe launches read data and status
                    statusDataOutClock <= 1'b1;
                    dly_ff <= bpsh_pkg::CNT_W'(bpsh_pkg::SETUP_CYC);
                    state_ff <= bpsh_pkg::ST_SETUP;
                end
                bpsh_pkg::ST_SETUP: begin
                    if (dly_ff != '0) begin
                        dly_ff <= dly_ff - 1'b1;
                    end else if (filtOk) begin
                        // DK or DI edge only after the setup tap
                        ackLvl_ff <= !ackLvl_ff;
                        dkN <= ackLvl_ff;
                        diN <= !ackLvl_ff;
                        state_ff <= bpsh_pkg::ST_BEAT;
                    end
                end
                bpsh_pkg::ST_DISC: begin
                    // AK held until final status has settled on the bus
                    if (dly_ff != '0) begin
                        dly_ff <= dly_ff - 1'b1;
                    end else if (!acipA) begin
                        akN <= 1'b1;
                        aiN <= 1'b1;
                        dkN <= 1'b1;
                        diN <= 1'b1;
                        state_ff <= bpsh_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= bpsh_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Latches, direction and memory write
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latchAddrEn <= 1'b1;
            latchStatusEn <= 1'b1;
            rxStatus <= '0;
            writeDirN <= 1'b0;
            memWrite <= 1'b0;
        end else begin
            latchAddrEn <= !sel;
            // Status freezes on filtered AI and holds until AS release
            if (!asA) begin
                latchStatusEn <= 1'b1;
            end else if (aiFilt && latchStatusEn) begin
                latchStatusEn <= 1'b0;
                rxStatus <= busStatus;
            end
            writeDirN <= (state_ff != bpsh_pkg::ST_IDLE) && !wrA && !ivRd_ff;
            memWrite <= wrA || ivRd_ff;
        end
    end

    // Two-entry buffer between bus beats and the memory side
    bpsh_fifo uFifo (
        .clk(clk),
        .rst_n(rst_n),
        .inIf(wrIf),
        .outIf(rdIf)
    );

    assign rdIf.ready = memReady;
    assign memValid = rdIf.valid;
    assign memData = rdIf.data;

    // Cycles since the output strobe, saturating
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sinceClk_ff <= 3'h7;
        end else if (statusDataOutClock) begin
            sinceClk_ff <= 3'h0;
        end else if (sinceClk_ff != 3'h7) begin
            sinceClk_ff <= sinceClk_ff + 3'h1;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence sReqHeld;
        (sel && launchOk) [*2];
    endsequence

    a_req_latency: assert property (sReqHeld |=> !areqN)
        else $error("access request late after held select");
    a_req_two_edges: assert property ($fell(areqN) |-> $past(sel, 1) && $past(sel, 2))
        else $error("access request without two captures");
    a_read_waits_ds: assert property ($fell(areqN) |-> $past(launchOk))
        else $error("read launched before data strobe");
    a_status_latch: assert property (asA && aiFilt && latchStatusEn
        |=> !latchStatusEn && rxStatus == $past(busStatus))
        else $error("status not latched on filtered AI");
    a_glitch_reject: assert property ($changed(filt_ff[0])
        |-> $past(rawHs[0], 1) == filt_ff[0] && $past(rawHs[0], 2) == filt_ff[0])
        else $error("short DK pulse passed filter");
    a_strobe_pulse: assert property (statusDataOutClock |=> !statusDataOutClock)
        else $error("output strobe longer than one cycle");
    a_ack_setup: assert property (($changed(dkN) || $fell(aiN)) && !akN
        |-> sinceClk_ff >= 3'(bpsh_pkg::SETUP_CYC))
        else $error("handshake edge before setup tap");
    a_ak_release: assert property ($rose(akN)
        |-> sinceClk_ff >= 3'(bpsh_pkg::DISC_CYC) && !$past(asA, 4))
        else $error("AK released too soon after AS");
    a_iv_write: assert property (ivRd_ff && state_ff == bpsh_pkg::ST_SETUP |-> memWrite)
        else $error("intervened read not turned into write");
endmodule

//--- hdl/bpsh_pkg.sv
package bpsh_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_MHZ = 125;
    localparam int SETUP_TAP_NS = 10;
    localparam int DISC_TAP_NS = 30;
    localparam int GLITCH_NS = 8;
    localparam int SYNC_MAX_NS = 80;

    // Least times round up, never below one cycle
    function automatic int minCycles(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    // Longest times round down, never below one cycle
    function automatic int maxCycles(input int ns);
        int c;
        c = (ns * CLK_MHZ) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int SETUP_CYC = minCycles(SETUP_TAP_NS);
    localparam int DISC_CYC = minCycles(DISC_TAP_NS);
    localparam int GLITCH_CYC = minCycles(GLITCH_NS);
    localparam int SYNC_MAX_CYC = maxCycles(SYNC_MAX_NS);
    localparam int CNT_W = 4;

    // ****************************************
    // Widths and pin vector layout
    // ****************************************
    localparam int DATA_W = 32;
    localparam int STAT_W = 8;
    localparam int PIN_W = 11;
    localparam int P_AS = 0;
    localparam int P_DS = 1;
    localparam int P_DK = 2;
    localparam int P_DI = 3;
    localparam int P_AI = 4;
    localparam int P_CS = 5;
    localparam int P_WR = 6;
    localparam int P_IV = 7;
    localparam int P_BC = 8;
    localparam int P_ACIP = 9;
    localparam int P_DACK = 10;
    localparam logic [PIN_W-1:0] PIN_RST = 11'h3FF;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ASETUP, ST_BEAT, ST_ACC, ST_WAITD,
        ST_PUSH, ST_CLK, ST_SETUP, ST_DISC
    } bpsh_state_t;

endpackage

//--- hdl/bpsh_stream_if.sv
interface bpsh_stream_if #(parameter int W = 32);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface

//--- hdl/bpsh_sync.sv
module bpsh_sync #(parameter int W = 1, parameter logic [W-1:0] RST = '0) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins in, clean levels out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;

    // A change counts only once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_ff <= RST;
            s2_ff <= RST;
            s3_ff <= RST;
            dout <= RST;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (int i = 0; i < W; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    dout[i] <= s3_ff[i];
                end
            end
        end
    end
endmodule

//--- hdl/bpsh_fifo.sv
module bpsh_fifo (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill and drain sides
    bpsh_stream_if.snk inIf,
    bpsh_stream_if.src outIf
);
    logic [bpsh_pkg::DATA_W-1:0] mem_ff [2];
    logic wp_ff;
    logic rp_ff;
    logic [1:0] cnt_ff;
    logic full_ff;
    logic pushOk;
    logic popOk;
    logic [1:0] nxt_cnt;

    assign inIf.ready = !full_ff;
    assign outIf.data = mem_ff[rp_ff];
    assign pushOk = inIf.valid && !full_ff;
    assign popOk = outIf.valid && outIf.ready;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (pushOk && !popOk) begin
            nxt_cnt = cnt_ff + 2'h1;
        end else if (popOk && !pushOk) begin
            nxt_cnt = cnt_ff - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_ff <= 1'b0;
            rp_ff <= 1'b0;
            cnt_ff <= 2'h0;
            full_ff <= 1'b0;
            outIf.valid <= 1'b0;
        end else begin
            if (pushOk) begin
                wp_ff <= !wp_ff;
            end
            if (popOk) begin
                rp_ff <= !rp_ff;
            end
            cnt_ff <= nxt_cnt;
            full_ff <= (nxt_cnt == 2'h2);
            outIf.valid <= (nxt_cnt != 2'h0);
        end
    end

    // Storage needs no reset; valid guards it
    always_ff @(posedge clk) begin
        if (pushOk) begin
            mem_ff[wp_ff] <= inIf.data;
        end
    end

    a_fifo_no_overrun: assert property (@(posedge clk) disable iff (!rst_n)
        (cnt_ff == 2'h2) |-> !inIf.ready && outIf.valid)
        else $error("buffer full yet still accepting");
endmodule

//--- sim/bpsh_master_model.sv
module bpsh_master_model (
    // Clock
    input wire logic clk,
    // Transfer order from the bench
    input wire logic go,
    input wire logic goWr,
    input wire logic goIv,
    input wire logic [3:0] goBeats,
    // Slave answers
    input wire logic akN,
    input wire logic aiN,
    input wire logic dkN,
    input wire logic diN,
    // Bus pins driven by this master
    output logic asN,
    output logic dsN,
    output logic csN,
    output logic wrN,
    output logic ivN,
    output logic [31:0] busData,
    output logic [7:0] nDone
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // One transaction per go pulse
    // ****************************************
    initial begin
        asN = 1'b1;
        dsN = 1'b1;
        csN = 1'b1;
        wrN = 1'b1;
        ivN = 1'b1;
        busData = 32'hFFFFFFFF;
        nDone = 8'h00;
        forever begin
            @(posedge clk);
            if (go === 1'b1) begin
                csN <= 1'b0;
                wrN <= ~goWr;
                ivN <= ~goIv;
                busData <= 32'hB0A00000;
                // Command settles before AS
                repeat (2) @(posedge clk);
                asN <= 1'b0;
                while (aiN !== 1'b0) @(posedge clk);
                // Whole words only, short bursts inside one page
                for (int b = 0; b < 32'(goBeats); b++) begin
                    busData <= 32'hB0A00000 + 32'(b);
                    // Data settles before DS edge
                    repeat (2) @(posedge clk);
                    dsN <= ~dsN;
                    do @(posedge clk);
                    while (((b % 2 == 0) ? dkN : diN) !== 1'b0);
                end
                // AS release only from the last answer, delayed
                repeat (2) @(posedge clk);
                asN <= 1'b1;
                while (akN !== 1'b1) @(posedge clk);
                dsN <= 1'b1;
                csN <= 1'b1;
                wrN <= 1'b1;
                ivN <= 1'b1;
                // Released lines do not keep the last word
                busData <= ~busData;
                nDone <= nDone + 8'h01;
            end
        end
    end
endmodule

//--- sim/bpsh_ctrl_tb.sv
module bpsh_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Signals and bookkeeping
    // ****************************************
    logic clk, rst_n, dkInN, diInN, aiInN, dack, acipN, memReady, go, goWr, goIv;
    logic asN, dsN, csN, wrN, ivN, akN, aiN, dkN, diN, statusDataOutClock;
    logic latchAddrEn, latchStatusEn, writeDirN, areqN, dtStb, memWrite, memValid;
    logic lastStb, accWr, akStb, areqAtDs, dirAtDs, bcastN;
    logic [3:0] goBeats;
    logic [7:0] busStatus, rxStatus, nDone;
    logic [31:0] busData, memData;
    logic [31:0] got[$];
    int n_errors, n_tests, cyc, tStb, nStb, tAs, tReq, tAsRel, tAkRel, nStbRel, nStbAk;
    int nAcc, accAtDs, nAns;

    bpsh_ctrl bpsh_ctrl_i (.clk(clk), .rst_n(rst_n), .asN(asN), .dsN(dsN),
        .dkInN(dkInN), .diInN(diInN), .aiInN(aiInN), .akN(akN), .aiN(aiN), .dkN(dkN),
        .diN(diN), .csN(csN), .wrN(wrN), .ivN(ivN), .bcastN(bcastN), .busData(busData),
        .busStatus(busStatus), .statusDataOutClock(statusDataOutClock),
        .latchAddrEn(latchAddrEn), .latchStatusEn(latchStatusEn), .writeDirN(writeDirN),
        .rxStatus(rxStatus), .areqN(areqN), .dtStb(dtStb), .memWrite(memWrite),
        .dack(dack), .acipN(acipN), .memValid(memValid), .memReady(memReady),
        .memData(memData));

    bpsh_master_model bpsh_master_model_i (.clk(clk), .go(go), .goWr(goWr), .goIv(goIv),
        .goBeats(goBeats), .akN(akN), .aiN(aiN), .dkN(dkN), .diN(diN), .asN(asN),
        .dsN(dsN), .csN(csN), .wrN(wrN), .ivN(ivN), .busData(busData), .nDone(nDone));

    // ****************************************
    // Clock, memory partner, monitors
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Memory answers each strobe edge after a few cycles
    initial begin
        lastStb = 1'b0;
        forever begin
            @(posedge clk);
            if (rst_n === 1'b1 && dtStb !== lastStb) begin
                lastStb = dtStb;
                accWr = memWrite;
                nAcc++;
                acipN <= 1'b0;
                repeat (3) @(posedge clk);
                dack <= ~dack;
                acipN <= 1'b1;
            end
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (rst_n === 1'b1) begin
            if (statusDataOutClock === 1'b1) begin
                tStb = cyc;
                nStb++;
            end
            if ($fell(asN)) tAs = cyc;
            if ($fell(areqN)) tReq = cyc;
            if ($fell(akN)) akStb = statusDataOutClock;
            if ($rose(asN)) begin
                tAsRel = cyc;
                nStbRel = nStb;
            end
            if ($rose(akN)) begin
                tAkRel = cyc;
                nStbAk = nStb;
            end
            if ($fell(dsN)) begin
                areqAtDs = areqN;
                accAtDs = nAcc;
                dirAtDs = writeDirN;
            end
            if ($fell(aiN)) chkBit(1'b1, cyc - tStb >= bpsh_pkg::SETUP_CYC);
            if ($fell(dkN) || $fell(diN)) begin
                nAns++;
                chkBit(1'b1, cyc - tStb >= bpsh_pkg::SETUP_CYC);
            end
            if (memValid === 1'b1 && memReady === 1'b1) got.push_back(memData);
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chkBit(input logic exp, input logic val);
        n_tests++;
        if (val !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, val);
        end
    endtask

    task automatic chkWord(input logic [31:0] exp, input logic [31:0] val);
        n_tests++;
        if (val !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, val);
        end
    endtask

    task automatic run(input logic wr, input logic iv, input logic [3:0] beats);
        logic [7:0] d;
        d = nDone;
        goWr <= wr;
        goIv <= iv;
        goBeats <= beats;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        while (nDone === d) @(posedge clk);
        repeat (4) @(posedge clk);
    endtask

    task automatic chkWords(input int n);
        chkWord(32'(n), 32'(got.size()));
        for (int i = 0; i < n; i++) chkWord(32'hB0A00000 + 32'(i), got[i]);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        chkWord(32'h000003F8, {22'h000000, akN, aiN, dkN, diN, areqN, latchAddrEn,
            latchStatusEn, memValid, statusDataOutClock, dtStb});
    endtask

    task automatic t_write();
        got.delete();
        run(1'b1, 1'b0, 4'h2);
        chkWords(2);
        chkBit(1'b0, areqAtDs);
        chkBit(1'b1, tReq - tAs >= 2);
        chkBit(1'b1, tReq - tAs <= bpsh_pkg::SYNC_MAX_CYC);
        chkBit(1'b1, akStb);
        chkBit(1'b1, accWr);
        chkBit(1'b1, tAkRel - tAsRel >= bpsh_pkg::DISC_CYC);
        chkBit(1'b1, nStbAk > nStbRel);
    endtask

    task automatic t_read();
        int base;
        base = nAcc;
        run(1'b0, 1'b0, 4'h2);
        chkBit(1'b1, areqAtDs);
        chkBit(1'b1, accAtDs == base);
        chkBit(1'b1, dirAtDs);
        chkBit(1'b0, accWr);
        chkBit(1'b1, nAcc - base == 2);
    endtask

    // Other board owns the data; a one-cycle DK spike must not count
    task automatic t_interv();
        busStatus <= 8'h5A;
        fork
            run(1'b0, 1'b1, 4'h1);
            begin
                while (aiN !== 1'b0) @(posedge clk);
                aiInN <= 1'b0;
                // Change only after the filtered AI has frozen the status
                repeat (10) @(posedge clk);
                busStatus <= 8'hC3;
                while (dsN !== 1'b0) @(posedge clk);
                repeat (16) @(posedge clk);
                dkInN <= 1'b0;
                @(posedge clk);
                dkInN <= 1'b1;
                repeat (10) @(posedge clk);
                chkBit(1'b1, dkN);
                chkBit(1'b0, latchStatusEn);
                chkWord(32'h0000005A, {24'h000000, rxStatus});
                chkBit(1'b0, writeDirN);
                chkBit(1'b0, latchAddrEn);
                dkInN <= 1'b0;
            end
        join
        dkInN <= 1'b1;
        aiInN <= 1'b1;
        chkBit(1'b1, accWr);
    endtask

    // Broadcast write: the answer waits for the other boards' DK
    task automatic t_bcast();
        bcastN <= 1'b0;
        fork
            run(1'b1, 1'b0, 4'h1);
            begin
                while (dsN !== 1'b0) @(posedge clk);
                repeat (40) @(posedge clk);
                chkBit(1'b1, dkN);
                dkInN <= 1'b0;
            end
        join
        dkInN <= 1'b1;
        bcastN <= 1'b1;
    endtask

    // Receiver stalls: third beat must wait for buffer room
    task automatic t_stall();
        int base;
        base = nAns;
        got.delete();
        memReady <= 1'b0;
        fork
            run(1'b1, 1'b0, 4'h3);
            begin
                repeat (150) @(posedge clk);
                chkWord(32'h00000002, 32'(nAns - base));
                chkBit(1'b1, memValid);
                memReady <= 1'b1;
            end
        join
        chkWords(3);
        chkBit(1'b0, memValid);
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        rst_n = 1'b0;
        dkInN = 1'b1;
        diInN = 1'b1;
        aiInN = 1'b1;
        dack = 1'b0;
        acipN = 1'b1;
        memReady = 1'b1;
        go = 1'b0;
        goWr = 1'b0;
        goIv = 1'b0;
        goBeats = 4'h0;
        busStatus = 8'h00;
        bcastN = 1'b1;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        t_reset();
        t_write();
        t_read();
        t_interv();
        t_bcast();
        t_stall();
        results();
    end

    // Whole run needs well under a few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        results();
    end
endmodule
